/* File: src/dcrl_repeater.sv */
// Logic unit of a dual CAN repeater transceiver
`timescale 1ns/100ps
`include "dcrl_defs.svh"
module dcrl_repeater #(
	parameter int TDOM_CYC = `DCRL_TDOM_CYC,
	parameter int FBS_CYC = `DCRL_FBS_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic node_transmit_in,
	input wire logic exp_transmit_in,
	input wire logic bus1_disable_in,
	input wire logic bus2_disable_in,
	input wire logic bus1_sense_in,
	input wire logic bus2_sense_in,
	output logic node_receive_out,
	output logic exp_receive_out,
	output logic bus1_drive_out,
	output logic bus2_drive_out
);
	localparam int TW = $clog2(TDOM_CYC + 2);
	localparam int FW = $clog2(FBS_CYC + `DCRL_SENSE_LAT + 2);

	// Pin synchronisers, all preset recessive
	logic [2:0] s_ntx_q, s_etx_q, s_d1_q, s_d2_q, s_r1_q, s_r2_q;
	dcrl_pkg::dcrl_lines_t pin_q;
	logic dis1_q, dis2_q;
	dcrl_pkg::dcrl_state_t st_q;
	logic [TW-1:0] tmr_q [4];
	logic [3:0] tmo_q;
	logic [FW-1:0] fb1_q, fb2_q;

	function automatic logic agree(input logic [2:0] s, input logic prev);
		agree = (s[1] == s[2]) ? s[2] : prev;
	endfunction : agree

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_ntx_q <= 3'h7;
			s_etx_q <= 3'h7;
			s_d1_q <= 3'h7;
			s_d2_q <= 3'h7;
			s_r1_q <= 3'h7;
			s_r2_q <= 3'h7;
			pin_q <= 4'hF;
			dis1_q <= 1'b1;
			dis2_q <= 1'b1;
		end else begin
			s_ntx_q <= {s_ntx_q[1:0], node_transmit_in};
			s_etx_q <= {s_etx_q[1:0], exp_transmit_in};
			s_d1_q <= {s_d1_q[1:0], bus1_disable_in};
			s_d2_q <= {s_d2_q[1:0], bus2_disable_in};
			s_r1_q <= {s_r1_q[1:0], bus1_sense_in};
			s_r2_q <= {s_r2_q[1:0], bus2_sense_in};
			pin_q.node_tx <= agree(s_ntx_q, pin_q.node_tx);
			pin_q.exp_tx <= agree(s_etx_q, pin_q.exp_tx);
			pin_q.bus1_rx <= agree(s_r1_q, pin_q.bus1_rx);
			pin_q.bus2_rx <= agree(s_r2_q, pin_q.bus2_rx);
			dis1_q <= agree(s_d1_q, dis1_q);
			dis2_q <= agree(s_d2_q, dis2_q);
		end
	end

	// Receiver gating by disable and by feedback suppression
	wire rx1_gated = dis1_q | (fb1_q != '0) | pin_q.bus1_rx;
	wire rx2_gated = dis2_q | (fb2_q != '0) | pin_q.bus2_rx;
	wire [3:0] tmr_in = {rx2_gated, rx1_gated, pin_q.exp_tx, pin_q.node_tx};

	// Dominant time-out timers: tmo_q bit low is dominant after timer
	genvar g;
	for (g = 0; g < 4; g++) begin : g_tmr
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				tmr_q[g] <= '0;
				tmo_q[g] <= `DCRL_REC;
			end else if (tmr_in[g] == `DCRL_DOM) begin
				if (tmr_q[g] <= TW'(TDOM_CYC))
					tmr_q[g] <= tmr_q[g] + TW'(1);
				tmo_q[g] <= (tmr_q[g] >= TW'(TDOM_CYC)) ? `DCRL_REC : `DCRL_DOM;
			end else begin
				tmr_q[g] <= '0;
				tmo_q[g] <= `DCRL_REC;
			end
		end
	end

	wire run = (st_q == dcrl_pkg::DCRL_RUN);
	wire t_ntx = tmo_q[0];
	wire t_etx = tmo_q[1];
	wire t_rx1 = tmo_q[2];
	wire t_rx2 = tmo_q[3];
	wire any_rx_dom = ~t_rx1 | ~t_rx2;
	wire tx_dom = ~t_ntx | ~t_etx;
	// Each bus repeats only the other bus, so its own dominant cannot latch itself
	wire drv1_d = run & ~dis1_q & (tx_dom | ~t_rx2);
	wire drv2_d = run & ~dis2_q & (tx_dom | ~t_rx1);
	wire nrx_d = ~run | ~(any_rx_dom | tx_dom);
	wire erx_d = ~run | ~(any_rx_dom | ~t_ntx);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_q <= dcrl_pkg::DCRL_INIT;
		end else begin
			case (st_q)
				dcrl_pkg::DCRL_INIT: st_q <= dcrl_pkg::DCRL_RUN;
				dcrl_pkg::DCRL_RUN: st_q <= dcrl_pkg::DCRL_RUN;
				default: st_q <= dcrl_pkg::DCRL_INIT;
			endcase
		end
	end

	// Feedback suppression: held while driving, then counts down
	// The hold spans the sense pipeline too, so the line's own echo never reaches the timers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			fb1_q <= '0;
			fb2_q <= '0;
		end else begin
			if (bus1_drive_out)
				fb1_q <= FW'(FBS_CYC + `DCRL_SENSE_LAT);
			else if (fb1_q != '0)
				fb1_q <= fb1_q - FW'(1);
			if (bus2_drive_out)
				fb2_q <= FW'(FBS_CYC + `DCRL_SENSE_LAT);
			else if (fb2_q != '0)
				fb2_q <= fb2_q - FW'(1);
		end
	end

	// Outputs: drive high means active driver (dominant on the line)
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			bus1_drive_out <= 1'b0;
			bus2_drive_out <= 1'b0;
			node_receive_out <= `DCRL_REC;
			exp_receive_out <= `DCRL_REC;
		end else begin
			bus1_drive_out <= drv1_d;
			bus2_drive_out <= drv2_d;
			node_receive_out <= nrx_d;
			exp_receive_out <= erx_d;
		end
	end

	property p_dis1_passive;
		@(posedge clk_in) disable iff (sys_rst_in) dis1_q |=> !bus1_drive_out;
	endproperty
	a_dis1_passive: assert property (p_dis1_passive) else $error("bus1 driven while disabled");

	property p_dis2_passive;
		@(posedge clk_in) disable iff (sys_rst_in) dis2_q |=> !bus2_drive_out;
	endproperty
	a_dis2_passive: assert property (p_dis2_passive) else $error("bus2 driven while disabled");

	property p_ntx_both;
		@(posedge clk_in) disable iff (sys_rst_in) (run && !t_ntx) |=> (!node_receive_out && !exp_receive_out);
	endproperty
	a_ntx_both: assert property (p_ntx_both) else $error("node tx not reflected on both receive outputs");

	property p_etx_local;
		@(posedge clk_in) disable iff (sys_rst_in) (run && !t_etx && t_ntx && !any_rx_dom) |=> (!node_receive_out && exp_receive_out);
	endproperty
	a_etx_local: assert property (p_etx_local) else $error("expansion tx routed wrongly");

	property p_tx_drive;
		@(posedge clk_in) disable iff (sys_rst_in) (run && tx_dom && !dis1_q) |=> bus1_drive_out;
	endproperty
	a_tx_drive: assert property (p_tx_drive) else $error("enabled bus1 not driven on tx dominant");

	property p_rx_spread;
		@(posedge clk_in) disable iff (sys_rst_in) (run && any_rx_dom) |=> (!node_receive_out && !exp_receive_out);
	endproperty
	a_rx_spread: assert property (p_rx_spread) else $error("received dominant not spread");

	property p_timeout;
		@(posedge clk_in) disable iff (sys_rst_in) (tmr_q[0] > TW'(TDOM_CYC)) |-> t_ntx;
	endproperty
	a_timeout: assert property (p_timeout) else $error("node tx timer did not time out");

	property p_mask;
		@(posedge clk_in) disable iff (sys_rst_in) bus1_drive_out |=> rx1_gated;
	endproperty
	a_mask: assert property (p_mask) else $error("bus1 reception not masked while driving");

	property p_reset_out;
		@(posedge clk_in) sys_rst_in |=> (!bus1_drive_out && !bus2_drive_out && node_receive_out);
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");

	// Repeat and disable checks for both buses, bus2 tx drive and mask checks, idle before run
	property p_rx1_repeat;
		@(posedge clk_in) disable iff (sys_rst_in) (run && !t_rx1 && !dis2_q) |=> bus2_drive_out;
	endproperty
	a_rx1_repeat: assert property (p_rx1_repeat) else $error("bus1 dominant not repeated on bus2");

	property p_rx2_repeat;
		@(posedge clk_in) disable iff (sys_rst_in) (run && !t_rx2 && !dis1_q) |=> bus1_drive_out;
	endproperty
	a_rx2_repeat: assert property (p_rx2_repeat) else $error("bus2 dominant not repeated on bus1");

	property p_tx_drive2;
		@(posedge clk_in) disable iff (sys_rst_in) (run && tx_dom && !dis2_q) |=> bus2_drive_out;
	endproperty
	a_tx_drive2: assert property (p_tx_drive2) else $error("enabled bus2 not driven on tx dominant");

	property p_dis1_rx;
		@(posedge clk_in) disable iff (sys_rst_in) dis1_q |=> t_rx1;
	endproperty
	a_dis1_rx: assert property (p_dis1_rx) else $error("bus1 reception seen while disabled");

	property p_dis2_rx;
		@(posedge clk_in) disable iff (sys_rst_in) dis2_q |=> t_rx2;
	endproperty
	a_dis2_rx: assert property (p_dis2_rx) else $error("bus2 reception seen while disabled");

	property p_mask2;
		@(posedge clk_in) disable iff (sys_rst_in) bus2_drive_out |=> rx2_gated;
	endproperty
	a_mask2: assert property (p_mask2) else $error("bus2 reception not masked while driving");

	property p_init_idle;
		@(posedge clk_in) disable iff (sys_rst_in) !run |=> (!bus1_drive_out && !bus2_drive_out);
	endproperty
	a_init_idle: assert property (p_init_idle) else $error("bus driven before initialisation");
endmodule : dcrl_repeater

/* File: inc/dcrl_defs.svh */
// Constants of the dual CAN repeater logic
`ifndef DCRL_DEFS_SVH
`define DCRL_DEFS_SVH

`define DCRL_CLK_PERIOD_NS 10
`define DCRL_TDOM_US 1000
`define DCRL_TDOM_CYC ((`DCRL_TDOM_US * 1000) / `DCRL_CLK_PERIOD_NS)
`define DCRL_FBS_NS 200
`define DCRL_FBS_CYC ((`DCRL_FBS_NS + `DCRL_CLK_PERIOD_NS - 1) / `DCRL_CLK_PERIOD_NS)
// Edges from a bus drive change until its sensed level settles in the pin filter
`define DCRL_SENSE_LAT 4
`define DCRL_DOM 1'b0
`define DCRL_REC 1'b1

`endif

/* File: inc/dcrl_pkg.sv */
// Types of the dual CAN repeater logic
package dcrl_pkg;
	typedef struct packed {
		logic node_tx;
		logic exp_tx;
		logic bus1_rx;
		logic bus2_rx;
	} dcrl_lines_t;

	typedef enum logic [1:0] {
		DCRL_INIT = 2'b01,
		DCRL_RUN = 2'b10
	} dcrl_state_t;
endpackage : dcrl_pkg

/* File: tb/dcrl_bus_model.sv */
// Bus line model joining the device driver and the other nodes
`timescale 1ns/100ps
module dcrl_bus_model (
	input wire logic drive_in,
	input wire logic other_dom_in,
	output logic sense_out
);
	// Any active driver pulls the line dominant
	assign sense_out = (drive_in | other_dom_in) ? 1'b0 : 1'b1;
endmodule : dcrl_bus_model

/* File: tb/dcrl_repeater_tb_top.sv */
// Self-checking bench of the repeater logic
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module dcrl_repeater_tb_top;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ntx = 1'b1, etx = 1'b1, dis1 = 1'b0, dis2 = 1'b0, oth1 = 1'b0, oth2 = 1'b0;
	logic s1, s2, nrx, erx, drv1, drv2;
	wire logic [3:0] obs = {drv1, drv2, nrx, erx};
	int compares = 0;
	int miscompares = 0;
	dcrl_repeater #(.TDOM_CYC(20), .FBS_CYC(3)) dcrl_repeater_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.node_transmit_in(ntx), .exp_transmit_in(etx), .bus1_disable_in(dis1), .bus2_disable_in(dis2),
		.bus1_sense_in(s1), .bus2_sense_in(s2), .node_receive_out(nrx), .exp_receive_out(erx),
		.bus1_drive_out(drv1), .bus2_drive_out(drv2));
	dcrl_bus_model dcrl_bus_model_inst1 (.drive_in(drv1), .other_dom_in(oth1), .sense_out(s1));
	dcrl_bus_model dcrl_bus_model_inst2 (.drive_in(drv2), .other_dom_in(oth2), .sense_out(s2));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	// Order: node tx, exp tx, disable 1, disable 2, other node on bus 1, on bus 2
	task set_pins(input logic [5:0] v, input int n);
		@(posedge clk_in);
		#1 {ntx, etx, dis1, dis2, oth1, oth2} = v;
		repeat (n) @(posedge clk_in);
		#1;
	endtask : set_pins
	task t_node;
		set_pins(6'h10, 10);
		`CHK(obs, 4'hC)
		set_pins(6'h30, 20);
		`CHK(obs, 4'h3)
		set_pins(6'h1C, 10);
		`CHK(obs, 4'h0)
		set_pins(6'h30, 20);
		$display("node transmit test done");
	endtask : t_node
	task t_exp;
		set_pins(6'h20, 10);
		`CHK(obs, 4'hD)
		set_pins(6'h30, 20);
		$display("expansion transmit test done");
	endtask : t_exp
	task t_bus;
		set_pins(6'h32, 10);
		`CHK(obs[2:0], 3'h4)
		set_pins(6'h30, 20);
		`CHK(obs, 4'h3)
		set_pins(6'h31, 10);
		`CHK(obs, 4'h8)
		set_pins(6'h30, 20);
		`CHK(obs, 4'h3)
		$display("bus repeat test done");
	endtask : t_bus
	task t_fault;
		set_pins(6'h3A, 10);
		`CHK(obs, 4'h3)
		set_pins(6'h1A, 10);
		`CHK(obs, 4'h4)
		set_pins(6'h30, 20);
		$display("bus fault test done");
	endtask : t_fault
	task t_timeout;
		set_pins(6'h10, 15);
		`CHK(obs, 4'hC)
		set_pins(6'h10, 25);
		`CHK(obs, 4'h3)
		set_pins(6'h30, 20);
		$display("time-out test done");
	endtask : t_timeout
	initial begin
		repeat (3) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		`CHK(obs, 4'h3)
		$display("reset test done");
		t_node();
		t_exp();
		t_bus();
		t_fault();
		t_timeout();
		close_out();
	end
	initial begin
		#50000;
		miscompares++;
		close_out();
	end
endmodule : dcrl_repeater_tb_top
